// [inc/pdtil_pkg.sv]
// Package of constants, types and rate decode for the port default tag and ingress limiter.
`default_nettype none
package pdtil_pkg;
    // Register indices as printed; the byte address is four times the index.
    localparam logic [3:0] IDX_TAG = 4'h4;
    localparam logic [3:0] IDX_CTRL3 = 4'h6;
    localparam logic [3:0] IDX_RATE = 4'h8;
    localparam logic [11:0] ADDR_TAG = {6'h00, IDX_TAG, 2'b00};
    localparam logic [11:0] ADDR_CTRL3 = {6'h00, IDX_CTRL3, 2'b00};
    localparam logic [11:0] ADDR_RATE = {6'h00, IDX_RATE, 2'b00};

    // Reset values.
    localparam logic [15:0] TAG_RST = 16'h0001;
    localparam logic [4:0] CTRL3_RST = 5'h00;
    localparam logic [15:0] RATE_RST = 16'h0000;

    // Field positions of the default tag.
    localparam int TAG_PRIO_LSB = 13;
    localparam int TAG_CFI_BIT = 12;
    localparam int TAG_VID_W = 12;

    // Field positions of the limit and accounting control; bits 15-5 are not stored.
    localparam int CTRL3_W = 5;
    localparam int LIM_CLASS_LSB = 2;
    localparam int GAP_BIT = 1;
    localparam int PRE_BIT = 0;

    // Rate code fields, one nibble per priority, priority 0 in the low nibble.
    localparam int RATE_W = 4;
    localparam int NUM_PRIO = 4;
    localparam logic [3:0] CODE_UNLIMITED = 4'h0;
    localparam logic [3:0] CODE_FIRST_ABOVE_10M = 4'h9;

    // Per-frame overhead bytes.
    localparam logic [4:0] GAP_BYTES = 5'h0c;
    localparam logic [4:0] PRE_BYTES = 5'h08;

    // Timing: measurement window and clock rate.
    localparam int CLK_KHZ = 10000;
    localparam int WINDOW_US = 1000;
    localparam int WINDOW_CYCLES = WINDOW_US * CLK_KHZ / 1000;
    localparam int BITS_PER_BYTE = 8;
    localparam int COUNT_W = 16;

    // Frame classes that the limiter counts.
    typedef enum logic [1:0] {
        pdtil_lim_all,
        pdtil_lim_flood,
        pdtil_lim_multi,
        pdtil_lim_bcast
    } pdtil_class_t;

    // Register bus phase.
    typedef enum logic {
        pdtil_apb_idle,
        pdtil_apb_answer
    } pdtil_apb_t;

    // Rate in kbit/s selected by a four-bit code; zero means unlimited.
    function automatic logic [31:0] rate_kbps(input logic [3:0] code);
        logic [31:0] r;
        r = 32'h0;
        unique case (code)
            4'h0: r = 32'd0;
            4'h1: r = 32'd64;
            4'h2: r = 32'd128;
            4'h3: r = 32'd256;
            4'h4: r = 32'd512;
            4'h5: r = 32'd1000;
            4'h6: r = 32'd2000;
            4'h7: r = 32'd4000;
            4'h8: r = 32'd8000;
            4'h9: r = 32'd16000;
            4'ha: r = 32'd32000;
            4'hb: r = 32'd48000;
            4'hc: r = 32'd64000;
            4'hd: r = 32'd72000;
            4'he: r = 32'd80000;
            4'hf: r = 32'd88000;
        endcase
        return r;
    endfunction : rate_kbps
endpackage : pdtil_pkg
`default_nettype wire

// [sim/pdtil_tb_top.sv]
// Self-checking testbench for the port default tag and ingress limiter block.
`default_nettype none
module pdtil_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // A short window keeps the run brief; budget bytes are kbps * WIN / 80000.
    localparam int WIN = 1000;

    // One row: class code, frame kind, tag fields, then the expected decision.
    typedef struct packed {
        logic [1:0] cls;
        logic bc;
        logic mc;
        logic fl;
        logic tg;
        logic [11:0] vid;
        logic cnt;
        logic [11:0] lvid;
    } pdtil_row_t;

    logic clk_in, resetn_in, psel_in, penable_in, pwrite_in, link_10m_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [3:0] pstrb_in;
    logic pready_out, pslverr_out, err;
    logic frm_valid_in, frm_tagged_in, frm_bcast_in, frm_mcast_in, frm_flood_in;
    logic [11:0] frm_vid_in, lookup_vid_out;
    logic [1:0] frm_prio_in;
    logic [10:0] frm_len_in;
    logic dec_valid_out, dec_discard_out, dec_counted_out, dec_untagged_out;
    logic [15:0] default_tag_out;
    logic [4:0] overhead_bytes_out;
    int n_errors = 0;
    int samples_checked = 0;

    // Class rows cover every code against every frame kind, default VID 0x123.
    pdtil_row_t rows [16] = '{
        '{2'd0, 1'b0, 1'b0, 1'b0, 1'b0, 12'h7ff, 1'b1, 12'h123}, '{2'd0, 1'b0, 1'b0, 1'b1, 1'b1, 12'h000, 1'b1, 12'h123},
        '{2'd0, 1'b0, 1'b1, 1'b0, 1'b1, 12'h456, 1'b1, 12'h456}, '{2'd0, 1'b1, 1'b0, 1'b0, 1'b0, 12'h7ff, 1'b1, 12'h123},
        '{2'd1, 1'b0, 1'b0, 1'b0, 1'b1, 12'h000, 1'b0, 12'h123}, '{2'd1, 1'b0, 1'b0, 1'b1, 1'b1, 12'h456, 1'b1, 12'h456},
        '{2'd1, 1'b0, 1'b1, 1'b0, 1'b0, 12'h7ff, 1'b1, 12'h123}, '{2'd1, 1'b1, 1'b0, 1'b0, 1'b1, 12'h000, 1'b1, 12'h123},
        '{2'd2, 1'b0, 1'b0, 1'b0, 1'b1, 12'h456, 1'b0, 12'h456}, '{2'd2, 1'b0, 1'b0, 1'b1, 1'b0, 12'h7ff, 1'b0, 12'h123},
        '{2'd2, 1'b0, 1'b1, 1'b0, 1'b1, 12'h000, 1'b1, 12'h123}, '{2'd2, 1'b1, 1'b0, 1'b0, 1'b1, 12'h456, 1'b1, 12'h456},
        '{2'd3, 1'b0, 1'b0, 1'b0, 1'b0, 12'h7ff, 1'b0, 12'h123}, '{2'd3, 1'b0, 1'b0, 1'b1, 1'b1, 12'h000, 1'b0, 12'h123},
        '{2'd3, 1'b0, 1'b1, 1'b0, 1'b1, 12'h456, 1'b0, 12'h456}, '{2'd3, 1'b1, 1'b0, 1'b0, 1'b0, 12'h7ff, 1'b1, 12'h123}
    };

    pdtil_top #(.WINDOW_CYCLES(WIN)) u_dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .link_10m_in(link_10m_in),
        .frm_valid_in(frm_valid_in), .frm_tagged_in(frm_tagged_in), .frm_vid_in(frm_vid_in),
        .frm_prio_in(frm_prio_in), .frm_bcast_in(frm_bcast_in), .frm_mcast_in(frm_mcast_in),
        .frm_flood_in(frm_flood_in), .frm_len_in(frm_len_in), .dec_valid_out(dec_valid_out),
        .dec_discard_out(dec_discard_out), .dec_counted_out(dec_counted_out),
        .dec_untagged_out(dec_untagged_out), .lookup_vid_out(lookup_vid_out),
        .default_tag_out(default_tag_out), .overhead_bytes_out(overhead_bytes_out)
    );

    // Free-running 10 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Prints the verdict and ends the run; also reached when a wait runs out.
    task automatic close_out();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // Compares one value and counts it; four-state compare so unknowns never match.
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1) begin
            n_errors++;
            close_out();
        end else begin
            rd = prdata_out;
            err = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask : apb

    // Reads a register and checks both the data and the error response.
    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, addr, 32'h0);
        chk("prdata", rd, exp);
        chk("pslverr", 32'(err), 32'(exp_err));
    endtask : rd_chk

    // Presents one 64-byte frame descriptor; returns in the cycle its decision stands.
    task automatic frame(input logic [1:0] pr, input logic bc, mc, fl, tg, input logic [11:0] vid);
        @(posedge clk_in);
        frm_valid_in <= 1'b1;
        frm_prio_in <= pr;
        frm_bcast_in <= bc;
        frm_mcast_in <= mc;
        frm_flood_in <= fl;
        frm_tagged_in <= tg;
        frm_vid_in <= vid;
        @(posedge clk_in);
        frm_valid_in <= 1'b0;
        @(negedge clk_in);
    endtask : frame

    // Checks the decision pulse of the frame just presented.
    task automatic fchk(input logic dis, input logic cnt);
        chk("dec_valid", 32'(dec_valid_out), 32'h1);
        chk("dec_discard", 32'(dec_discard_out), 32'(dis));
        chk("dec_counted", 32'(dec_counted_out), 32'(cnt));
    endtask : fchk

    // Main sequence: registers, class table, overhead, metering, second reset.
    initial begin
        {psel_in, penable_in, pwrite_in, link_10m_in, frm_valid_in, frm_tagged_in} = 6'h00;
        {frm_bcast_in, frm_mcast_in, frm_flood_in, frm_prio_in} = 5'h00;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        pstrb_in = 4'hf;
        frm_vid_in = 12'h000;
        frm_len_in = 11'd64;
        resetn_in = 1'b0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        chk("default_tag_out", 32'(default_tag_out), 32'h1);
        rd_chk(pdtil_pkg::ADDR_TAG, 32'h1, 1'b0);
        rd_chk(pdtil_pkg::ADDR_CTRL3, 32'h0, 1'b0);
        rd_chk(pdtil_pkg::ADDR_RATE, 32'h0, 1'b0);
        apb(1'b1, pdtil_pkg::ADDR_CTRL3, 32'hffff_ffff);
        rd_chk(pdtil_pkg::ADDR_CTRL3, 32'h1f, 1'b0);
        apb(1'b1, pdtil_pkg::ADDR_RATE, 32'h0000_abcd);
        rd_chk(pdtil_pkg::ADDR_RATE, 32'habcd, 1'b0);
        apb(1'b1, 12'h024, 32'h0000_5555);
        chk("pslverr", 32'(err), 32'h1);
        rd_chk(12'h024, 32'h0, 1'b1);
        rd_chk(pdtil_pkg::ADDR_RATE, 32'habcd, 1'b0);
        apb(1'b1, pdtil_pkg::ADDR_RATE, 32'h0);
        apb(1'b1, pdtil_pkg::ADDR_TAG, 32'h0000_6123);
        rd_chk(pdtil_pkg::ADDR_TAG, 32'h6123, 1'b0);
        chk("default_tag_out", 32'(default_tag_out), 32'h6123);
        // Rate codes are zero here, so nothing may be discarded whatever the class.
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, pdtil_pkg::ADDR_CTRL3, {28'h0, rows[i].cls, 2'b00});
            frame(2'(i), rows[i].bc, rows[i].mc, rows[i].fl, rows[i].tg, rows[i].vid);
            fchk(1'b0, rows[i].cnt);
            chk("dec_untagged", 32'(dec_untagged_out), 32'(!rows[i].tg));
            chk("lookup_vid", 32'(lookup_vid_out), 32'(rows[i].lvid));
        end
        // Each overhead setting shows one cycle after the write lands.
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, pdtil_pkg::ADDR_CTRL3, 32'(v));
            repeat (2) @(negedge clk_in);
            chk("overhead", 32'(overhead_bytes_out), 32'((v[1] ? 12 : 0) + (v[0] ? 8 : 0)));
        end
        // 1 Mbit/s gives a 12-byte budget; each 84-byte frame exhausts it.
        apb(1'b1, pdtil_pkg::ADDR_RATE, 32'h5555);
        for (int p = 0; p < 4; p++) begin
            frame(2'(p), 1'b1, 1'b0, 1'b0, 1'b0, 12'h0);
            fchk(1'b0, 1'b1);
            frame(2'(p), 1'b1, 1'b0, 1'b0, 1'b0, 12'h0);
            fchk(1'b1, 1'b1);
        end
        // On a slow port 16 Mbit/s is unlimited while 8 Mbit/s (100 bytes) still limits.
        apb(1'b1, pdtil_pkg::ADDR_RATE, 32'h9800);
        link_10m_in <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            frame(2'd3, 1'b1, 1'b0, 1'b0, 1'b0, 12'h0);
            fchk(1'b0, 1'b1);
            frame(2'd2, 1'b1, 1'b0, 1'b0, 1'b0, 12'h0);
            fchk(k == 2, 1'b1);
        end
        // A new window restarts the count.
        repeat (WIN + 5) @(posedge clk_in);
        frame(2'd2, 1'b1, 1'b0, 1'b0, 1'b0, 12'h0);
        fchk(1'b0, 1'b1);
        // Broadcast-only class: unicast is neither counted nor limited.
        apb(1'b1, pdtil_pkg::ADDR_CTRL3, 32'h0f);
        repeat (3) begin
            frame(2'd2, 1'b0, 1'b0, 1'b0, 1'b0, 12'h0);
            fchk(1'b0, 1'b0);
        end
        // A second reset in mid-run restores the register defaults.
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd_chk(pdtil_pkg::ADDR_TAG, 32'h1, 1'b0);
        rd_chk(pdtil_pkg::ADDR_RATE, 32'h0, 1'b0);
        close_out();
    end
endmodule : pdtil_tb_top
`default_nettype wire

// [verilog/pdtil_rate_meter.sv]
// Byte meter for one priority: counts bytes per window and flags when the budget is reached.
`default_nettype none
module pdtil_rate_meter #(
    parameter int WINDOW_CYCLES = pdtil_pkg::WINDOW_CYCLES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic tick_in,
    input wire logic [3:0] code_in,
    input wire logic add_in,
    input wire logic [15:0] add_bytes_in,
    output logic limit_out
);
    typedef struct packed {
        logic [3:0] code;
        logic [15:0] count;
    } pdtil_meter_t;

    pdtil_meter_t st;
    pdtil_meter_t next_st;
    logic [31:0] budget_wide;
    logic [15:0] budget;
    logic [16:0] sum;

    // Budget in bytes per window; derived from the window length so a shortened window scales with it.
    assign budget_wide = (pdtil_pkg::rate_kbps(code_in) * 32'(WINDOW_CYCLES))
        / 32'(pdtil_pkg::CLK_KHZ * pdtil_pkg::BITS_PER_BYTE); // [R12] [R17]
    assign budget = budget_wide[15:0];
    assign sum = {1'b0, st.count} + {1'b0, add_bytes_in};

    // Limit once the counted bytes reach or exceed the budget; code zero never limits.
    assign limit_out = (code_in != pdtil_pkg::CODE_UNLIMITED) && (st.count >= budget); // [R10] [R11] [R14] [R15]

    // A new window or a new code restarts the count; a frame in that same cycle is still counted.
    always_comb begin
        next_st = st;
        next_st.code = code_in;
        if (tick_in || (code_in != st.code)) begin
            next_st.count = add_in ? add_bytes_in : 16'h0000; // [R17]
        end else if (add_in) begin
            next_st.count = sum[16] ? 16'hffff : sum[15:0];
        end
    end

    // Meter state; the count starts empty after reset.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // The count restarts from zero at a window boundary with no frame.
    window_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R17]
        (tick_in && !add_in) |=> (st.count == 16'h0000))
        else $error("meter count did not restart at window end");

    // A code change restarts the count as well.
    code_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R17]
        ($changed(code_in) && !add_in) |=> (st.count == 16'h0000))
        else $error("meter count did not restart on code change");
endmodule : pdtil_rate_meter
`default_nettype wire

// [verilog/pdtil_top.sv]
// Port default tag, limit accounting control and per-priority ingress rate limiter with APB access.
// Function
// [R1] A 16-bit default tag holds priority in 15-13, CFI in 12 and VID in 11-0, resetting to VID 1 with the rest zero.
// [R2] The default tag is attached to untagged ingress frames and offered for tag insertion on egress.
// [R3] Untagged frames and frames tagged with VID zero use the default VID for address lookup.
// [R4] Class code 00 counts and limits every frame.
// [R5] Class code 01 counts and limits broadcast, multicast and flooded unicast, leaving known unicast alone.
// [R6] Class code 10 counts and limits broadcast and multicast only.
// [R7] Class code 11 counts and limits broadcast only.
// [R8] The gap bit adds 12 bytes per frame to ingress and egress accounting.
// [R9] The preamble bit adds 8 bytes per frame to ingress and egress accounting.
// [R10] The nibble in bits 15-12 sets the rate above which priority-3 frames are discarded.
// [R11] The nibble in bits 11-8 sets the rate above which priority-2 frames are discarded.
// [R12] Codes decode as unlimited, 64, 128, 256, 512 kbit/s, then 1, 2, 4, 8, 16, 32, 48, 64, 72, 80, 88 Mbit/s.
// [R13] On a 10 Mbit/s port any code above 10 Mbit/s acts as unlimited.
// [R14] The nibble in bits 7-4 sets the rate above which priority-1 frames are discarded.
// [R15] The nibble in bits 3-0 sets the rate above which priority-0 frames are discarded.
// [R16] Bits 15-5 of the limit and accounting control read as zero and ignore writes.
// [R17] Each priority's rate is bytes per clock-derived window, restarting after reset or a code change.
`default_nettype none
module pdtil_top #(
    parameter int WINDOW_CYCLES = pdtil_pkg::WINDOW_CYCLES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic link_10m_in,
    input wire logic frm_valid_in,
    input wire logic frm_tagged_in,
    input wire logic [11:0] frm_vid_in,
    input wire logic [1:0] frm_prio_in,
    input wire logic frm_bcast_in,
    input wire logic frm_mcast_in,
    input wire logic frm_flood_in,
    input wire logic [10:0] frm_len_in,
    output logic dec_valid_out,
    output logic dec_discard_out,
    output logic dec_counted_out,
    output logic dec_untagged_out,
    output logic [11:0] lookup_vid_out,
    output logic [15:0] default_tag_out,
    output logic [4:0] overhead_bytes_out
);
    typedef struct packed {
        pdtil_pkg::pdtil_apb_t apb;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic [15:0] tag;
        logic [4:0] ctrl3;
        logic [15:0] rate;
        logic [15:0] win_cnt;
        logic tick;
        logic dec_valid;
        logic dec_discard;
        logic dec_counted;
        logic dec_untagged;
        logic [11:0] lookup_vid;
        logic [4:0] ovh;
    } pdtil_state_t;

    localparam logic [15:0] WIN_LAST = 16'(WINDOW_CYCLES - 1);

    pdtil_state_t st;
    pdtil_state_t next_st;
    logic [3:0] limit;
    logic [3:0] eff_code [pdtil_pkg::NUM_PRIO];
    logic [3:0] add_sel;
    logic counted;
    logic limited;
    logic [15:0] frame_bytes;
    logic [4:0] ovh_now;
    logic mapped;
    logic [31:0] rd_data;
    pdtil_pkg::pdtil_class_t lim_class;

    // Per-byte-lane write merge for the 16-bit registers.
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] strb
    );
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // Overhead bytes per frame, shared by ingress metering and the egress shaper.
    assign ovh_now = (st.ctrl3[pdtil_pkg::GAP_BIT] ? pdtil_pkg::GAP_BYTES : 5'h00) // [R8]
        + (st.ctrl3[pdtil_pkg::PRE_BIT] ? pdtil_pkg::PRE_BYTES : 5'h00); // [R9]
    assign frame_bytes = {5'h00, frm_len_in} + {11'h000, ovh_now};

    // Frame class selection decides whether a frame is counted and subject to limiting.
    assign lim_class =
        pdtil_pkg::pdtil_class_t'(st.ctrl3[pdtil_pkg::LIM_CLASS_LSB +: 2]);
    always_comb begin
        counted = 1'b0;
        unique case (lim_class)
            pdtil_pkg::pdtil_lim_all: counted = 1'b1; // [R4]
            pdtil_pkg::pdtil_lim_flood: counted = frm_bcast_in || frm_mcast_in || frm_flood_in; // [R5]
            pdtil_pkg::pdtil_lim_multi: counted = frm_bcast_in || frm_mcast_in; // [R6]
            pdtil_pkg::pdtil_lim_bcast: counted = frm_bcast_in; // [R7]
        endcase
    end

    // A counted frame is dropped when its priority's meter has reached the budget.
    assign limited = counted && limit[frm_prio_in]; // [R10] [R11] [R14] [R15]

    // One meter per priority; a 10 Mbit/s port treats codes above 10 Mbit/s as unlimited.
    generate
        for (genvar p = 0; p < pdtil_pkg::NUM_PRIO; p++) begin : g_prio
            assign eff_code[p] = (link_10m_in && (st.rate[p*pdtil_pkg::RATE_W +: pdtil_pkg::RATE_W]
                >= pdtil_pkg::CODE_FIRST_ABOVE_10M)) ? pdtil_pkg::CODE_UNLIMITED
                : st.rate[p*pdtil_pkg::RATE_W +: pdtil_pkg::RATE_W]; // [R13]
            assign add_sel[p] = frm_valid_in && counted && !limited
                && (frm_prio_in == 2'(p));
            pdtil_rate_meter #(
                .WINDOW_CYCLES(WINDOW_CYCLES)
            ) u_meter (
                .clk_in(clk_in),
                .resetn_in(resetn_in),
                .tick_in(st.tick),
                .code_in(eff_code[p]),
                .add_in(add_sel[p]),
                .add_bytes_in(frame_bytes),
                .limit_out(limit[p])
            );
        end
    endgenerate

    // Read mux; unmapped addresses answer with an error and zero data.
    always_comb begin
        mapped = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (paddr_in)
            pdtil_pkg::ADDR_TAG: rd_data = {16'h0000, st.tag}; // [R1]
            pdtil_pkg::ADDR_CTRL3: rd_data = {27'h0000000, st.ctrl3}; // [R16]
            pdtil_pkg::ADDR_RATE: rd_data = {16'h0000, st.rate};
            default: mapped = 1'b0;
        endcase
    end

    // Next state: bus slave, window timer and per-frame decision.
    always_comb begin
        next_st = st;
        // The answer is raised one cycle into the access phase so all bus outputs come from flops.
        unique case (st.apb)
            pdtil_pkg::pdtil_apb_idle: begin
                if (psel_in && penable_in) begin
                    next_st.apb = pdtil_pkg::pdtil_apb_answer;
                    next_st.pready = 1'b1;
                    next_st.pslverr = !mapped;
                    next_st.prdata = pwrite_in ? 32'h0000_0000 : rd_data;
                end
            end
            pdtil_pkg::pdtil_apb_answer: begin
                next_st.apb = pdtil_pkg::pdtil_apb_idle;
                next_st.pready = 1'b0;
                next_st.pslverr = 1'b0;
                next_st.prdata = 32'h0000_0000;
                // The write lands on the edge at which the master sees pready.
                if (psel_in && penable_in && pwrite_in) begin
                    unique case (paddr_in)
                        pdtil_pkg::ADDR_TAG: next_st.tag = merge16(st.tag, pwdata_in, pstrb_in); // [R1]
                        pdtil_pkg::ADDR_CTRL3: begin
                            if (pstrb_in[0]) begin
                                next_st.ctrl3 = pwdata_in[pdtil_pkg::CTRL3_W-1:0]; // [R16]
                            end
                        end
                        pdtil_pkg::ADDR_RATE: next_st.rate = merge16(st.rate, pwdata_in, pstrb_in);
                        default: next_st.ctrl3 = st.ctrl3;
                    endcase
                end
            end
        endcase

        // Window timer: one tick every WINDOW_CYCLES cycles.
        next_st.tick = (st.win_cnt == WIN_LAST); // [R17]
        next_st.win_cnt = next_st.tick ? 16'h0000 : st.win_cnt + 16'h0001;

        // Per-frame decision, presented one cycle after the descriptor.
        next_st.dec_valid = frm_valid_in;
        next_st.dec_counted = frm_valid_in && counted;
        next_st.dec_discard = frm_valid_in && limited;
        next_st.dec_untagged = frm_valid_in && !frm_tagged_in; // [R2]
        if (frm_valid_in) begin
            next_st.lookup_vid = (!frm_tagged_in || (frm_vid_in == 12'h000))
                ? st.tag[pdtil_pkg::TAG_VID_W-1:0] : frm_vid_in; // [R3]
        end

        // Egress shaping reads this flop, so it trails a control write by one cycle.
        next_st.ovh = ovh_now; // [R8] [R9]
    end

    // The three registers take their reset values; every other field starts at zero.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
            st.apb <= pdtil_pkg::pdtil_apb_idle;
            st.tag <= pdtil_pkg::TAG_RST; // [R1]
            st.ctrl3 <= pdtil_pkg::CTRL3_RST;
            st.rate <= pdtil_pkg::RATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops; the tag register feeds egress insertion directly.
    assign prdata_out = st.prdata;
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign dec_valid_out = st.dec_valid;
    assign dec_discard_out = st.dec_discard;
    assign dec_counted_out = st.dec_counted;
    assign dec_untagged_out = st.dec_untagged;
    assign lookup_vid_out = st.lookup_vid;
    assign default_tag_out = st.tag; // [R2]
    assign overhead_bytes_out = st.ovh;

    // An access phase gets its answer one cycle later, and pready stays up for one cycle only.
    apb_answer_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (psel_in && penable_in && !st.pready) |=> (st.pready ##1 !st.pready))
        else $error("apb answer not one cycle after access");

    // A read of the control register never shows bits above bit 4.
    reserved_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R16]
        (psel_in && penable_in && !st.pready && !pwrite_in
        && paddr_in == pdtil_pkg::ADDR_CTRL3)
        |=> (st.prdata[31:5] == 27'h0000000))
        else $error("reserved control bits read non-zero");

    // Untagged or null-VID frames look up with the default VID.
    lookup_vid_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R3]
        (frm_valid_in && (!frm_tagged_in || frm_vid_in == 12'h000))
        |=> (lookup_vid_out == $past(st.tag[11:0])))
        else $error("lookup vid not the default vid");

    // Class 00 counts every frame.
    class_all_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R4]
        (frm_valid_in && st.ctrl3[3:2] == 2'b00) |=> dec_counted_out)
        else $error("frame not counted in class all");

    // Class 01 leaves known unicast uncounted.
    class_flood_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R5]
        (frm_valid_in && st.ctrl3[3:2] == 2'b01
        && !frm_bcast_in && !frm_mcast_in && !frm_flood_in)
        |=> !dec_counted_out)
        else $error("known unicast counted in class flood");

    // Class 10 leaves unicast uncounted and counts multicast.
    class_multi_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R6]
        (frm_valid_in && st.ctrl3[3:2] == 2'b10)
        |=> (dec_counted_out == $past(frm_bcast_in || frm_mcast_in)))
        else $error("class multi count wrong");

    // Class 11 counts broadcast alone.
    class_bcast_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R7]
        (frm_valid_in && st.ctrl3[3:2] == 2'b11) |=> (dec_counted_out == $past(frm_bcast_in)))
        else $error("class bcast count wrong");

    // Overhead follows the gap and preamble bits with 12 and 8 bytes.
    overhead_bytes_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R8] [R9]
        ##1 (overhead_bytes_out == ($past(st.ctrl3[1]) ? 5'h0c : 5'h00)
        + ($past(st.ctrl3[0]) ? 5'h08 : 5'h00)))
        else $error("overhead bytes wrong");

    // A 10 Mbit/s port never discards under a code above 10 Mbit/s, and unlimited never discards.
    ten_meg_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R13] [R12]
        (frm_valid_in && (st.rate[frm_prio_in*4 +: 4] == 4'h0
        || (link_10m_in && st.rate[frm_prio_in*4 +: 4] >= 4'h9))) |=> !dec_discard_out)
        else $error("discard under unlimited code");

    // Only counted frames may be discarded.
    discard_counted_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R10]
        dec_discard_out |-> dec_counted_out)
        else $error("uncounted frame discarded");

    // Every descriptor gets its decision pulse on the next edge.
    dec_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        frm_valid_in |=> dec_valid_out)
        else $error("decision pulse missing");

    // The untagged flag is the inverse of the descriptor's tag bit.
    untagged_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R2]
        frm_valid_in |=> (dec_untagged_out != $past(frm_tagged_in)))
        else $error("untagged flag wrong");
endmodule : pdtil_top
`default_nettype wire
